// file: logic/mbcd_map.vh
`ifndef MBCD_MAP_VH
`define MBCD_MAP_VH
// Two-bit codes held for every three-level strap.
`define MBCD_LVL_LOW 2'h0
`define MBCD_LVL_MID 2'h1
`define MBCD_LVL_HIGH 2'h2
// Strap positions in the strap vectors.
`define MBCD_NSTRAP 22
`define MBCD_IDX_FS 0
`define MBCD_IDX_BANK_THREE_INVERT_STRAP 1
`define MBCD_IDX_OMODE 2
`define MBCD_IDX_FBPH 3
`define MBCD_IDX_FBDS0 4
`define MBCD_IDX_FBDS1 5
`define MBCD_IDX_BANK0 6
`define MBCD_BANK_STRIDE 4
`define MBCD_OFS_PH0 0
`define MBCD_OFS_PH1 1
`define MBCD_OFS_DS0 2
`define MBCD_OFS_DS1 3
// Reset value of the captured strap codes: every strap reads LOW.
`define MBCD_CFG_RST 44'h000_0000_0000
// Multiplication factors, low-speed and high-speed variant.
`define MBCD_N_LS_LOW 7'h40
`define MBCD_N_LS_MID 7'h20
`define MBCD_N_LS_HIGH 7'h10
`define MBCD_N_HS_LOW 7'h20
`define MBCD_N_HS_MID 7'h10
`define MBCD_N_HS_HIGH 7'h08
// Feedback bank skew in time units, two's complement.
`define MBCD_FB_SKEW_LOW 6'h3C
`define MBCD_FB_SKEW_HIGH 6'h04
// Lock is withheld this long after a reference change.
`define MBCD_RELOCK_NS 1000
`define MBCD_CLK_NS 20
`endif

// file: logic/mbcd_matrix.v
`timescale 1ns/10ps
`include "mbcd_map.vh"
module mbcd_matrix #(
  parameter HIGH_SPEED = 0
) (
  input wire clk, // phase generator clock, one time unit per cycle
  input wire rst_n, // asynchronous reset, active low
  input wire [21:0] strap_above, // three-level strap pins sensed near supply
  input wire [21:0] strap_below, // three-level strap pins sensed near ground
  input wire hold_idle, // device held idle, straps captured
  input wire [3:0] bank_disable_inputs, // per-bank disable, high disables
  input wire feedback_bank_disable, // feedback bank disable, high disables
  input wire ref_select, // selected reference input, 0 primary, 1 secondary
  input wire pll_lock_in, // lock status from the analog loop
  output reg [15:0] bank_out, // bank b bits 4b..4b+3 are qa0, qa1, qb0, qb1
  output reg [3:0] bank_oe, // output enable per bank, high drives
  output reg [1:0] feedback_bank_outputs, // feedback pair
  output reg feedback_bank_oe, // feedback pair output enable
  output reg lock, // lock indicator
  output reg factory_test, // factory test mode active
  output reg [1:0] freq_band, // selected nominal frequency band code
  output reg [6:0] tu_factor // multiplication factor in use
);
  localparam integer RELOCK_FULL =
    (`MBCD_RELOCK_NS + `MBCD_CLK_NS - 1) / `MBCD_CLK_NS;
  localparam [5:0] RELOCK_CYC = RELOCK_FULL[5:0];

  wire [43:0] strap_code;
  reg [43:0] cfg;
  reg [7:0] pin_m;
  reg [7:0] pin_s;
  reg ref_prev;
  reg [5:0] relock_cnt;
  reg [4:0] run;
  wire [4:0] raw;
  reg [49:0] period_vec;
  reg [49:0] start_vec;
  reg [6:0] n_fac;
  reg [23:0] skew_vec;
  reg [5:0] fb_skew;
  reg [1:0] omode;
  reg [1:0] inv_mode;
  reg inv_all;
  reg inv_odd;
  wire [3:0] dis_s;
  wire feedback_bank_disable_s;
  wire hold_s;
  wire lock_s;
  wire ref_s;
  wire [4:0] dis_all;
  wire [4:0] gated;
  integer b;
  integer rb;
  integer ob;

  function [3:0] tri_idx;
    input [1:0] hi;
    input [1:0] lo;
    begin
      tri_idx = {2'h0, hi} * 4'h3 + {2'h0, lo};
    end
  endfunction

  function [3:0] div_ratio;
    input [3:0] idx;
    begin
      case (idx)
        4'h6: div_ratio = 4'h8;
        4'h7: div_ratio = 4'hA;
        4'h8: div_ratio = 4'hC;
        default: div_ratio = idx + 4'h1;
      endcase
    end
  endfunction

  function [5:0] skew_inner;
    input [3:0] idx;
    begin
      skew_inner = {2'h0, idx} - 6'h04;
    end
  endfunction

  function [5:0] skew_outer;
    input [3:0] idx;
    input [5:0] follow_one;
    input [5:0] follow_two;
    begin
      case (idx)
        4'h0: skew_outer = 6'h38;
        4'h1: skew_outer = 6'h39;
        4'h2: skew_outer = 6'h3A;
        4'h3: skew_outer = follow_one;
        4'h5: skew_outer = follow_two;
        4'h6: skew_outer = 6'h06;
        4'h7: skew_outer = 6'h07;
        4'h8: skew_outer = 6'h08;
        default: skew_outer = 6'h00;
      endcase
    end
  endfunction

  // Turns a delay in time units into a counter start value inside one period.
  function [9:0] wrap;
    input [5:0] delay;
    input [9:0] p;
    reg [10:0] v;
    integer k;
    begin
      v = {{5{delay[5]}}, delay};
      for (k = 0; k < 2; k = k + 1) begin
        if (v[10])
          v = v + {1'b0, p};
        else if (v >= {1'b0, p})
          v = v - {1'b0, p};
      end
      wrap = v[9:0];
    end
  endfunction

  mbcd_tri_sync #(
    .W(`MBCD_NSTRAP)
  ) u_straps (
    .clk(clk),
    .rst_n(rst_n),
    .above(strap_above),
    .below(strap_below),
    .code(strap_code)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= 8'h00;
      pin_s <= 8'h00;
    end else begin
      pin_m <= {pll_lock_in, ref_select, hold_idle, feedback_bank_disable, bank_disable_inputs};
      pin_s <= pin_m;
    end
  end

  assign dis_s = pin_s[3:0];
  assign feedback_bank_disable_s = pin_s[4];
  assign hold_s = pin_s[5];
  assign ref_s = pin_s[6];
  assign lock_s = pin_s[7];

  // Straps are static; changing them mid-run would tear the phase relations.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= `MBCD_CFG_RST;
    end else if (hold_s) begin
      cfg <= strap_code;
    end
  end

  always @* begin
    omode = cfg[2*`MBCD_IDX_OMODE +: 2];
    inv_mode = cfg[2*`MBCD_IDX_BANK_THREE_INVERT_STRAP +: 2];
    case (cfg[2*`MBCD_IDX_FS +: 2])
      `MBCD_LVL_LOW: n_fac = HIGH_SPEED ? `MBCD_N_HS_LOW : `MBCD_N_LS_LOW;
      `MBCD_LVL_MID: n_fac = HIGH_SPEED ? `MBCD_N_HS_MID : `MBCD_N_LS_MID;
      default: n_fac = HIGH_SPEED ? `MBCD_N_HS_HIGH : `MBCD_N_LS_HIGH;
    endcase
    case (cfg[2*`MBCD_IDX_FBPH +: 2])
      `MBCD_LVL_LOW: fb_skew = `MBCD_FB_SKEW_LOW;
      `MBCD_LVL_HIGH: fb_skew = `MBCD_FB_SKEW_HIGH;
      default: fb_skew = 6'h00;
    endcase
    skew_vec = 24'h000000;
    period_vec = 50'h0;
    start_vec = 50'h0;
    for (b = 0; b < 2; b = b + 1) begin
      skew_vec[6*b +: 6] = skew_inner(tri_idx(
        cfg[2*(`MBCD_IDX_BANK0 + `MBCD_BANK_STRIDE*b + `MBCD_OFS_PH1) +: 2],
        cfg[2*(`MBCD_IDX_BANK0 + `MBCD_BANK_STRIDE*b + `MBCD_OFS_PH0) +: 2]));
    end
    for (b = 2; b < 4; b = b + 1) begin
      skew_vec[6*b +: 6] = skew_outer(tri_idx(
        cfg[2*(`MBCD_IDX_BANK0 + `MBCD_BANK_STRIDE*b + `MBCD_OFS_PH1) +: 2],
        cfg[2*(`MBCD_IDX_BANK0 + `MBCD_BANK_STRIDE*b + `MBCD_OFS_PH0) +: 2]),
        skew_vec[5:0], skew_vec[11:6]);
    end
    for (b = 0; b < 4; b = b + 1) begin
      period_vec[10*b +: 10] = {3'h0, n_fac} * {6'h00, div_ratio(tri_idx(
        cfg[2*(`MBCD_IDX_BANK0 + `MBCD_BANK_STRIDE*b + `MBCD_OFS_DS1) +: 2],
        cfg[2*(`MBCD_IDX_BANK0 + `MBCD_BANK_STRIDE*b + `MBCD_OFS_DS0) +: 2]))};
      start_vec[10*b +: 10] = wrap(6'h00 - (skew_vec[6*b +: 6] - fb_skew),
        period_vec[10*b +: 10]);
    end
    period_vec[49:40] = {3'h0, n_fac} * {6'h00, div_ratio(tri_idx(
      cfg[2*`MBCD_IDX_FBDS1 +: 2], cfg[2*`MBCD_IDX_FBDS0 +: 2]))};
    start_vec[49:40] = 10'h000;
  end

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_bank
      mbcd_phase_bank u_bank (
        .clk(clk),
        .rst_n(rst_n),
        .load(hold_s),
        .start(start_vec[10*g +: 10]),
        .period(period_vec[10*g +: 10]),
        .raw(raw[g])
      );
    end
  endgenerate

  assign dis_all = {feedback_bank_disable_s, dis_s};

  // Stopping only while the raw clock is low gives a glitch-free hold-off.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= 5'h00;
    end else begin
      for (rb = 0; rb < 5; rb = rb + 1) begin
        if (omode == `MBCD_LVL_MID)
          run[rb] <= 1'b1;
        else if (!raw[rb])
          run[rb] <= !dis_all[rb];
      end
    end
  end

  assign gated = raw & run;

  always @* begin
    inv_all = (inv_mode == `MBCD_LVL_HIGH);
    inv_odd = (inv_mode == `MBCD_LVL_HIGH) || (inv_mode == `MBCD_LVL_LOW);
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_out <= 16'h0000;
      bank_oe <= 4'h0;
      feedback_bank_outputs <= 2'h0;
      feedback_bank_oe <= 1'b0;
      factory_test <= 1'b0;
      freq_band <= `MBCD_LVL_LOW;
      tu_factor <= 7'h00;
    end else begin
      for (ob = 0; ob < 4; ob = ob + 1) begin
        if (ob == 2) begin
          bank_out[4*ob +: 4] <= {gated[ob] ^ inv_odd, gated[ob] ^ inv_all,
                                  gated[ob] ^ inv_odd, gated[ob] ^ inv_all};
        end else begin
          bank_out[4*ob +: 4] <= {4{gated[ob]}};
        end
        bank_oe[ob] <= (omode == `MBCD_LVL_MID) ||
                       !(dis_all[ob] && omode == `MBCD_LVL_HIGH);
      end
      feedback_bank_outputs <= {2{gated[4]}};
      feedback_bank_oe <= (omode == `MBCD_LVL_MID) ||
                          !(dis_all[4] && omode == `MBCD_LVL_HIGH);
      factory_test <= (omode == `MBCD_LVL_MID);
      freq_band <= cfg[2*`MBCD_IDX_FS +: 2];
      tu_factor <= n_fac;
    end
  end

  // Outputs keep running from the phase counters across a reference change,
  // so no period is cut short; only the lock report is withheld.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev <= 1'b0;
      relock_cnt <= 6'h00;
      lock <= 1'b0;
    end else begin
      ref_prev <= ref_s;
      if (ref_s != ref_prev)
        relock_cnt <= RELOCK_CYC;
      else if (relock_cnt != 6'h00)
        relock_cnt <= relock_cnt - 6'h01;
      lock <= lock_s && (relock_cnt == 6'h00) && (ref_s == ref_prev) &&
              (omode != `MBCD_LVL_MID);
    end
  end
endmodule // mbcd_matrix

// file: logic/mbcd_phase_bank.v
`timescale 1ns/10ps
module mbcd_phase_bank (
  input wire clk, // phase generator clock, one time unit per cycle
  input wire rst_n, // asynchronous reset, active low
  input wire load, // restart the phase counter at start
  input wire [9:0] start, // counter value that realises the skew
  input wire [9:0] period, // output period in time units
  output reg raw // ungated bank clock
);
  reg [9:0] cnt;
  wire [9:0] next_cnt;

  assign next_cnt = load ? start : ((cnt + 10'h001 >= period) ? 10'h000 : cnt + 10'h001);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 10'h000;
      raw <= 1'b0;
    end else begin
      cnt <= next_cnt;
      raw <= (next_cnt < {1'b0, period[9:1]});
    end
  end
endmodule // mbcd_phase_bank

// file: logic/mbcd_tri_sync.v
`timescale 1ns/10ps
`include "mbcd_map.vh"
module mbcd_tri_sync #(
  parameter W = 22
) (
  input wire clk, // phase generator clock
  input wire rst_n, // asynchronous reset, active low
  input wire [W-1:0] above, // pin sensed near supply
  input wire [W-1:0] below, // pin sensed near ground
  output reg [2*W-1:0] code // two-bit level code per strap
);
  reg [W-1:0] above_m;
  reg [W-1:0] above_s;
  reg [W-1:0] below_m;
  reg [W-1:0] below_s;
  integer i;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      above_m <= {W{1'b0}};
      above_s <= {W{1'b0}};
      below_m <= {W{1'b0}};
      below_s <= {W{1'b0}};
    end else begin
      above_m <= above;
      above_s <= above_m;
      below_m <= below;
      below_s <= below_m;
    end
  end

  // An open pin floats to mid-supply and trips neither comparator.
  always @* begin
    code = {2*W{1'b0}};
    for (i = 0; i < W; i = i + 1) begin
      if (above_s[i])
        code[2*i +: 2] = `MBCD_LVL_HIGH;
      else if (below_s[i])
        code[2*i +: 2] = `MBCD_LVL_LOW;
      else
        code[2*i +: 2] = `MBCD_LVL_MID;
    end
  end
endmodule // mbcd_tri_sync

// file: verification/mbcd_board.sv
`timescale 1ns/10ps
module mbcd_board #(
  parameter ACQ = 20
) (
  input wire clk, // phase clock
  input wire [43:0] level, // two-bit level code per strap
  input wire want_lock, // reference present and steady
  output reg [21:0] strap_above, // pin near supply
  output reg [21:0] strap_below, // pin near ground
  output reg pll_lock_in // loop lock status
);
  integer i;
  integer cnt = 0;
  always @* begin
    for (i = 0; i < 22; i = i + 1) begin
      strap_above[i] = level[2*i+1];
      strap_below[i] = level[2*i +: 2] == 2'h0;
    end
  end
  always @(posedge clk) begin
    cnt <= want_lock ? (cnt < ACQ ? cnt + 1 : cnt) : 0;
    pll_lock_in <= want_lock && cnt == ACQ;
  end
endmodule // mbcd_board

// file: verification/mbcd_matrix_asserts.sv
`timescale 1ns/10ps
module mbcd_matrix_chk #(
  parameter HIGH_SPEED = 0
) (
  input wire clk, // phase clock
  input wire rst_n, // reset, active low
  input wire hold_idle, // strap capture
  input wire feedback_bank_disable, // feedback disable
  input wire ref_select, // reference select
  input wire pll_lock_in, // loop lock
  input wire [15:0] bank_out, // bank clocks
  input wire [3:0] bank_oe, // bank enables
  input wire [1:0] feedback_bank_outputs, // feedback pair
  input wire feedback_bank_oe, // feedback enable
  input wire lock, // lock flag
  input wire factory_test, // test mode
  input wire [1:0] freq_band, // band code
  input wire [6:0] tu_factor // factor in use
);
  wire [6:0] exp_n = (7'h40 >> HIGH_SPEED) >> freq_band;
  wire fb = feedback_bank_outputs[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  function automatic logic eq4(input logic [3:0] v);
    eq4 = (v == 4'h0) || (v == 4'hF);
  endfunction
  a_test_lock_low: assert property (factory_test |-> !lock)
    else $error("lock high in test mode");
  a_test_oe_all: assert property ((!hold_idle)[*6] ##0 factory_test |->
    (&bank_oe) && feedback_bank_oe) else $error("disable honoured in test mode");
  a_lock_follows_pll: assert property (!pll_lock_in [*5] |-> !lock)
    else $error("lock high while loop unlocked");
  a_relock_gap: assert property ($changed(ref_select) |-> ##[2:5] !lock [*8])
    else $error("lock kept across reference change");
  a_factor_map: assert property (tu_factor != 7'h00 |-> tu_factor == exp_n)
    else $error("factor does not match band");
  a_pairs_equal: assert property (eq4(bank_out[3:0]) && eq4(bank_out[7:4]) &&
    eq4(bank_out[15:12])) else $error("inversion outside bank three");
  a_fb_pair_eq: assert property (fb == feedback_bank_outputs[1])
    else $error("feedback pair differs");
  a_fb_high_min: assert property ($rose(fb) |-> fb [*4])
    else $error("feedback high phase too short");
  a_fboe_cause: assert property ($fell(feedback_bank_oe) && !hold_idle |->
    $past(feedback_bank_disable, 2) || $past(feedback_bank_disable, 3) ||
    $past(feedback_bank_disable, 4)) else $error("feedback released without disable");
  c_test: cover property (factory_test);
  c_relock: cover property ($fell(lock));
  c_lock: cover property ($rose(lock));
  c_fb_off: cover property ($fell(feedback_bank_oe));
endmodule // mbcd_matrix_chk
bind mbcd_matrix mbcd_matrix_chk #(.HIGH_SPEED(HIGH_SPEED)) u_chk (.clk(clk), .rst_n(rst_n),
  .hold_idle(hold_idle), .feedback_bank_disable(feedback_bank_disable),
  .ref_select(ref_select), .pll_lock_in(pll_lock_in), .bank_out(bank_out),
  .bank_oe(bank_oe), .feedback_bank_outputs(feedback_bank_outputs),
  .feedback_bank_oe(feedback_bank_oe), .lock(lock), .factory_test(factory_test),
  .freq_band(freq_band), .tu_factor(tu_factor));

// file: verification/mbcd_matrix_tb.sv
`timescale 1ns/10ps
module mbcd_matrix_tb;
  logic clk = 0, rst_n = 0, hold = 0, fdis = 0, rsel = 0, want = 1;
  logic [3:0] dis = 4'h0;
  logic [43:0] lvl = 44'h000_0000_0000;
  logic [15:0] sd = 16'h002C;
  logic [3:0] mk [3] = '{4'hA, 4'h0, 4'hF};
  wire [21:0] ab, bl;
  wire plk, foe, lk, ft;
  wire [15:0] bo;
  wire [3:0] oe;
  wire [1:0] fbo, band;
  wire [6:0] tf;
  int miscompares = 0, samples_checked = 0;
  int ph [4];
  always #10 clk = ~clk;
  mbcd_board u_brd (.clk(clk), .level(lvl), .want_lock(want), .strap_above(ab),
    .strap_below(bl), .pll_lock_in(plk));
  mbcd_matrix #(.HIGH_SPEED(0)) u_dut (.clk(clk), .rst_n(rst_n), .strap_above(ab),
    .strap_below(bl), .hold_idle(hold), .bank_disable_inputs(dis),
    .feedback_bank_disable(fdis), .ref_select(rsel), .pll_lock_in(plk), .bank_out(bo),
    .bank_oe(oe), .feedback_bank_outputs(fbo), .feedback_bank_oe(foe), .lock(lk),
    .factory_test(ft), .freq_band(band), .tu_factor(tf));
  function int rnd(int m);
    sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
    return sd % m;
  endfunction
  function int dv(int c);
    return c < 6 ? c + 1 : 2 * c - 4;
  endfunction
  // Banks three and four borrow the skew of bank one or two on codes 3 and 5.
  function int skw(int b, int c);
    if (b < 2) return c - 4;
    if (c == 3 || c == 5) return ph[c / 4] - 4;
    return c < 3 ? c - 8 : (c == 4 ? 0 : c);
  endfunction
  function logic sg(int k);
    return k > 15 ? fbo[0] : bo[k];
  endfunction
  task chk_v(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_n(string n, int e, int g);
    samples_checked++;
    if (e != g) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task put(int i, int v);
    lvl[2*i +: 2] = v[1:0];
  endtask
  // Straps are held steady through the whole idle window so capture is clean.
  task setup(int fs, int inv, int om, int fp, int fd);
    int b;
    put(0, fs);
    put(1, inv);
    put(2, om);
    put(3, fp);
    put(4, fd % 3);
    put(5, fd / 3);
    for (b = 0; b < 4; b++) begin
      put(6 + 4 * b, ph[b] % 3);
      put(7 + 4 * b, ph[b] / 3);
      put(8 + 4 * b, fd % 3);
      put(9 + 4 * b, fd / 3);
    end
    hold = 1;
    repeat (6) @(negedge clk);
    hold = 0;
    repeat (4) @(negedge clk);
  endtask
  task gap(int a, int b, output int d);
    logic qa, qb, ra, rb;
    int i;
    d = -1;
    qa = sg(a);
    qb = sg(b);
    for (i = 0; i < 2000; i++) begin
      @(negedge clk);
      ra = sg(a) && !qa;
      rb = sg(b) && !qb;
      qa = sg(a);
      qb = sg(b);
      if (d >= 0) d++;
      if (d < 0 && ra) d = 0;
      if (d >= 0 && rb && (a != b || d > 0)) break;
    end
    if (i == 2000) d = -1;
  endtask
  initial begin
    #1500000;
    miscompares++;
    close_out();
  end
  initial begin
    int j, b, d, n, p, inv, r;
    repeat (2) @(negedge clk);
    rst_n = 1;
    for (j = 0; j < 9; j++) begin
      for (b = 0; b < 4; b++) ph[b] = rnd(9);
      ph[0] = j;
      ph[3] = ph[2];
      inv = rnd(3);
      r = rnd(3);
      n = 64 >> (j % 3);
      p = n * dv(j);
      setup(j % 3, inv, 2, r, j);
      chk_v("band", j % 3, band);
      chk_v("factor", n, tf);
      chk_v("test", 0, ft);
      gap(16, 16, d);
      chk_n("fb period", p, d);
      gap(0, 0, d);
      chk_n("bank period", p, d);
      for (b = 0; b < 4; b++) begin
        gap(16, 4 * b, d);
        d = (d + (b == 2 && inv == 2 ? p / 2 : 0)) % p;
        chk_n("skew", ((skw(b, ph[b]) - 4 * (r - 1)) % p + p) % p, d);
      end
      repeat (8) begin
        @(negedge clk);
        chk_v("invert", {{4{bo[12]}} ^ mk[inv], {4{bo[4]}}}, bo[11:4]);
      end
      chk_v("lock", 1, lk);
      rsel = ~rsel;
      repeat (6) @(negedge clk);
      chk_v("relock", 0, lk);
    end
    // The relock hold of the last switch must run out, or the next check is blind.
    repeat (60) @(negedge clk);
    chk_v("lock back", 1, lk);
    want = 0;
    repeat (8) @(negedge clk);
    chk_v("lock lost", 0, lk);
    want = 1;
    b = rnd(4);
    dis[b] = 1'b1;
    fdis = 1;
    repeat (5) @(negedge clk);
    chk_v("hiz oe", {4'hF ^ (4'h1 << b), 1'b0}, {oe, foe});
    setup(2, inv, 0, r, 8);
    repeat (4) begin
      repeat (150) @(negedge clk);
      chk_v("holdoff", {b == 2 ? mk[inv] : 4'h0, 2'h0, 5'h1F},
        {bo[4*b +: 4], fbo, oe, foe});
    end
    dis = 4'h0;
    fdis = 0;
    gap(4 * b, 4 * b, d);
    chk_n("resume", 192, d);
    dis = 4'hF;
    setup(2, inv, 1, r, 8);
    chk_v("test mode", 6'h2F, {ft, lk, oe});
    close_out();
  end
endmodule // mbcd_matrix_tb
